// [eadp_cam.sv]
`default_nettype none
// ****************************************
// External compare logic on the far side.
// ****************************************
module eadp_cam (
  input wire logic clk,
  input wire logic arm,
  input wire logic sclk,
  input wire logic sdat,
  input wire logic mark,
  input wire logic [7:0] keep,
  input wire logic [3:0] low_cyc,
  output logic rej_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh;
  logic [3:0] n, lo;
  logic pc, pm;
  initial begin
    {sh, n, lo, pc, pm, rej_n} = 19'h1;
  end
  always @(posedge clk) begin
    pc <= sclk;
    pm <= mark;
    if (!arm) n <= 4'h0;
    else if (sclk && !pc && pm && n < 4'h8) begin
      sh <= {sdat, sh[7:1]};
      n <= n + 4'h1;
    end
    if (n == 4'h8) begin
      n <= 4'h9;
      if (sh != keep) lo <= low_cyc;
    end else if (lo != 4'h0) lo <= lo - 4'h1;
    rej_n <= (lo == 4'h0);
  end
endmodule
`default_nettype wire

// [eadp_pkg.sv]
`default_nettype none
package eadp_pkg;
  // Time of one received bit at 10 Mb/s, in ns.
  localparam int BIT_TIME_NS = 100;
  localparam int CLK_PERIOD_NS = 100;
  // Byte times after the delimiter beyond which the reject input is ignored.
  localparam int REJECT_WINDOW_BYTES = 64;
  localparam int REJECT_WINDOW_BITS = REJECT_WINDOW_BYTES * 8;
  // Least low time of the reject input, in ns, and in clock cycles rounded up.
  localparam int REJECT_MIN_NS = 200;
  localparam int REJECT_MIN_CYC = (REJECT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] SYNC_RESET_VAL = 2'h0;
  localparam logic [7:0] SHIFT_RESET_VAL = 8'h00;
  localparam logic [7:0] SFD_PATTERN = 8'hAB;
  localparam logic [2:0] BIT_COUNT_LAST = 3'h7;
  typedef enum logic [1:0] {EADP_IDLE, EADP_HUNT, EADP_DATA} eadp_state_t;
endpackage
`default_nettype wire

// [eadp_port.sv]
`default_nettype none
// Summary of operation
// - Port works only while the port select input is set.
// - Decoded receive bits and clock are presented; internal address compare runs alongside.
// - Serial receive clock output toggles only during frame reception.
// - Marker goes high when the two ones ending the delimiter are seen.
// - After the delimiter the marker toggles at each byte boundary.
// - Internal physical or group address match accepts the frame regardless of reject.
// - Failing frames keep being received, leaving time for external rejection.
// - Reject ignored after 64 byte times past delimiter; otherwise frame accepted.
// - Promiscuous mode receives every frame and ignores the reject input.
// - Physical reception off and group filter zero inputs are not read; an internal match still accepts the frame.
// - Port keeps working whenever port select and controller run are set, despite rx/tx disable.
module eadp_port #(
  parameter int WINDOW_BYTES = eadp_pkg::REJECT_WINDOW_BYTES,
  parameter int MIN_LOW_CYC = eadp_pkg::REJECT_MIN_CYC
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic EXT_ADDR_PORT_SELECT,
  input wire logic CONTROLLER_RUN,
  input wire logic TX_DISABLE,
  input wire logic RX_DISABLE,
  input wire logic PROMISCUOUS_MODE,
  input wire logic DISABLE_PHYS_ADDR_RX,
  input wire logic LOGICAL_ADDR_FILTER_ZERO,
  input wire logic STATION_ADDR_COMPARE,
  input wire logic RX_FRAME_ACTIVE,
  input wire logic RX_NRZ_CLOCK,
  input wire logic RX_NRZ_DATA,
  input wire logic EXTERNAL_REJECT_N,
  output logic SERIAL_RX_CLOCK_OUT,
  output logic SERIAL_RX_DATA_OUT,
  output logic FRAME_BYTE_MARKER,
  output logic FRAME_REJECT,
  output logic FRAME_ACCEPT,
  output logic PORT_ACTIVE
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    eadp_pkg::eadp_state_t state;
    logic clk_prev;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic [9:0] bits_after_sfd;
    logic [2:0] low_cnt;
    logic rejected;
    logic matched;
    logic srclk;
    logic srdata;
    logic marker;
    logic reject_out;
    logic accept_out;
    logic active;
  } eadp_port_t;
  eadp_port_t st_reg, st_next;
  logic [3:0] sync_in;
  logic act_s, clk_s, dat_s, rej_n_s;
  logic rise, enable, window_open, reject_usable;

  // ****************************************
  // Parameter checks
  // ****************************************
  // The window counter is ten bits wide and must not wrap.
  if (WINDOW_BYTES < 1 || WINDOW_BYTES * 8 > 1023) begin : g_window_check
    $error("eadp_port: WINDOW_BYTES must lie between 1 and 127");
  end
  // The low counter is three bits wide and saturates at its limit.
  if (MIN_LOW_CYC < 1 || MIN_LOW_CYC > 7) begin : g_low_check
    $error("eadp_port: MIN_LOW_CYC must lie between 1 and 7");
  end

  // ****************************************
  // Functions
  // ****************************************
  // A rejection holds only while nothing overrides it.
  function automatic logic reject_holds(input logic rejected, input logic usable);
    reject_holds = rejected & usable;
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  // The frame active, clock, data and reject inputs cross two flip-flops before any logic reads them.
  eadp_sync #(.WIDTH(4)) u_sync (
    .clk(CLK),
    .rst(SYS_RST),
    .d({RX_FRAME_ACTIVE, RX_NRZ_CLOCK, RX_NRZ_DATA, EXTERNAL_REJECT_N}),
    .q(sync_in)
  );
  assign {act_s, clk_s, dat_s, rej_n_s} = sync_in;
  assign rise = clk_s & ~st_reg.clk_prev;

  // ****************************************
  // Control terms
  // ****************************************
  // select gating
  assign enable = EXT_ADDR_PORT_SELECT & CONTROLLER_RUN;
  // The window counter stops at its limit, so a long frame never reopens it.
  // reject window
  assign window_open = st_reg.bits_after_sfd < 10'(WINDOW_BYTES * 8);
  assign reject_usable = ~PROMISCUOUS_MODE & ~st_reg.matched;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.clk_prev = clk_s;
    st_next.active = enable;
    st_next.accept_out = 1'b0;
    st_next.reject_out = 1'b0;
    st_next.srclk = enable & act_s & clk_s;
    st_next.srdata = enable & act_s & dat_s;
    if (STATION_ADDR_COMPARE && st_reg.state != eadp_pkg::EADP_IDLE) begin
      st_next.matched = 1'b1;
    end
    case (st_reg.state)
      eadp_pkg::EADP_IDLE: begin
        st_next.marker = 1'b0;
        st_next.shift = eadp_pkg::SHIFT_RESET_VAL;
        st_next.rejected = 1'b0;
        st_next.matched = 1'b0;
        st_next.low_cnt = '0;
        st_next.bits_after_sfd = '0;
        st_next.bit_cnt = '0;
        if (enable && act_s) begin
          st_next.state = eadp_pkg::EADP_HUNT;
        end
      end
      eadp_pkg::EADP_HUNT: begin
        if (rise) begin
          st_next.shift = {st_reg.shift[6:0], dat_s};
          if ({st_reg.shift[6:0], dat_s} == eadp_pkg::SFD_PATTERN) begin
            st_next.marker = 1'b1;
            st_next.state = eadp_pkg::EADP_DATA;
          end
        end
      end
      eadp_pkg::EADP_DATA: begin
        if (rise) begin
          st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
          if (window_open) begin
            st_next.bits_after_sfd = st_reg.bits_after_sfd + 10'h001;
          end
          if (st_reg.bit_cnt == eadp_pkg::BIT_COUNT_LAST) begin
            st_next.marker = ~st_reg.marker;
          end
        end
        if (!rej_n_s && window_open) begin
          if (st_reg.low_cnt != 3'(MIN_LOW_CYC)) begin
            st_next.low_cnt = st_reg.low_cnt + 3'h1;
          end
          if (st_reg.low_cnt == 3'(MIN_LOW_CYC - 1) && reject_usable) begin
            st_next.rejected = 1'b1;
          end
        end else begin
          st_next.low_cnt = '0;
        end
        if (!act_s || !enable) begin
          st_next.reject_out = reject_holds(st_reg.rejected, reject_usable);
          st_next.accept_out = ~reject_holds(st_reg.rejected, reject_usable);
          st_next.marker = 1'b0;
          st_next.state = eadp_pkg::EADP_IDLE;
        end
      end
      default: begin
        st_next.state = eadp_pkg::EADP_IDLE;
      end
    endcase
    if ((!enable || !act_s) && st_reg.state == eadp_pkg::EADP_HUNT) begin
      st_next.state = eadp_pkg::EADP_IDLE;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Reset returns every field to zero, which is also the idle state.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_reg <= '0;
      st_reg.state <= eadp_pkg::EADP_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output is read straight from a register.
  assign SERIAL_RX_CLOCK_OUT = st_reg.srclk;
  assign SERIAL_RX_DATA_OUT = st_reg.srdata;
  assign FRAME_BYTE_MARKER = st_reg.marker;
  assign FRAME_REJECT = st_reg.reject_out;
  assign FRAME_ACCEPT = st_reg.accept_out;
  assign PORT_ACTIVE = st_reg.active;
endmodule
`default_nettype wire

// [eadp_port_assertions.sv]
`default_nettype none
// ****************************************
// Checker of the port outputs.
// ****************************************
module eadp_port_assertions (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic EXT_ADDR_PORT_SELECT,
  input wire logic CONTROLLER_RUN,
  input wire logic PROMISCUOUS_MODE,
  input wire logic STATION_ADDR_COMPARE,
  input wire logic RX_FRAME_ACTIVE,
  input wire logic SERIAL_RX_CLOCK_OUT,
  input wire logic SERIAL_RX_DATA_OUT,
  input wire logic FRAME_BYTE_MARKER,
  input wire logic FRAME_REJECT,
  input wire logic FRAME_ACCEPT,
  input wire logic PORT_ACTIVE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_port_active: assert property (!$past(SYS_RST) |->
    PORT_ACTIVE == $past(EXT_ADDR_PORT_SELECT && CONTROLLER_RUN)) else $error("port active");
  a_off_quiet: assert property (!PORT_ACTIVE [*3] |->
    !SERIAL_RX_CLOCK_OUT && !SERIAL_RX_DATA_OUT) else $error("port off yet busy");
  a_idle_clock: assert property (!RX_FRAME_ACTIVE [*5] |->
    !SERIAL_RX_CLOCK_OUT) else $error("clock outside frame");
  a_marker_holds: assert property ($rose(FRAME_BYTE_MARKER) ##0 RX_FRAME_ACTIVE [*5] |->
    FRAME_BYTE_MARKER [*8]) else $error("marker too short");
  a_end_marker: assert property (FRAME_ACCEPT || FRAME_REJECT |->
    !FRAME_BYTE_MARKER) else $error("marker high at frame end");
  a_one_verdict: assert property (!(FRAME_ACCEPT && FRAME_REJECT)) else $error("two verdicts");
  a_accept_pulse: assert property (FRAME_ACCEPT |=> !FRAME_ACCEPT) else $error("long accept");
  a_promiscuous_mode_wins: assert property (PROMISCUOUS_MODE |-> !FRAME_REJECT) else $error("promiscuous_mode reject");
  a_match_wins: assert property (STATION_ADDR_COMPARE |-> !FRAME_REJECT) else $error("match rej");
endmodule
bind eadp_port eadp_port_assertions chk (.*);
`default_nettype wire

// [eadp_port_tb.sv]
`default_nettype none
// ****************************************
// Bench of the external address port.
// ****************************************
module eadp_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; $display("mismatch %s expected %0h seen %0h", n, e, g); end end
  logic clk, rst, sel, run, dis, promiscuous_mode, sam, fa, rclk, rdat, rej_n, sco, sdo, mark, rej, acc, pa;
  logic [7:0] keep;
  logic [3:0] low;
  int failures, checked, nacc, nrej, cyc;
  eadp_port dut (.CLK(clk), .SYS_RST(rst), .EXT_ADDR_PORT_SELECT(sel), .CONTROLLER_RUN(run),
    .TX_DISABLE(dis), .RX_DISABLE(dis), .PROMISCUOUS_MODE(promiscuous_mode), .DISABLE_PHYS_ADDR_RX(dis),
    .LOGICAL_ADDR_FILTER_ZERO(dis), .STATION_ADDR_COMPARE(sam), .RX_FRAME_ACTIVE(fa),
    .RX_NRZ_CLOCK(rclk), .RX_NRZ_DATA(rdat), .EXTERNAL_REJECT_N(rej_n),
    .SERIAL_RX_CLOCK_OUT(sco), .SERIAL_RX_DATA_OUT(sdo), .FRAME_BYTE_MARKER(mark),
    .FRAME_REJECT(rej), .FRAME_ACCEPT(acc), .PORT_ACTIVE(pa));
  eadp_cam cam (.clk(clk), .arm(fa), .sclk(sco), .sdat(sdo), .mark(mark), .keep(keep),
    .low_cyc(low), .rej_n(rej_n));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task end_sim;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (acc === 1'b1) nacc <= nacc + 1;
    if (rej === 1'b1) nrej <= nrej + 1;
    if (cyc == 10000) begin
      failures++;
      end_sim();
    end
  end
  task sbit(input logic b);
    rdat = b;
    repeat (4) @(negedge clk);
    rclk = 1'b1;
    repeat (4) @(negedge clk);
    rclk = 1'b0;
  endtask
  task frame(input logic s, d, p, m, input logic [7:0] k, input logic [3:0] lo, input logic er);
    int a0, r0;
    logic [7:0] dst;
    a0 = nacc;
    r0 = nrej;
    dst = 8'h5A;
    {sel, dis, promiscuous_mode, sam, keep, low, fa} = {s, d, p, m, k, lo, 1'b1};
    for (int i = 0; i < 16; i++) sbit(i == 15 || i % 2 == 0);
    `CHK("sfd marker", s, mark)
    `CHK("port active", s, pa)
    for (int i = 0; i < 8; i++) sbit(dst[i]);
    repeat (2) @(negedge clk);
    `CHK("byte marker", 1'b0, mark)
    for (int i = 0; i < 40; i++) sbit(dst[i % 8]);
    fa = 1'b0;
    repeat (8) @(negedge clk);
    sam = 1'b0;
    `CHK("idle clock", 1'b0, sco)
    `CHK("end marker", 1'b0, mark)
    `CHK("rejected", er, nrej != r0)
    `CHK("accepted", s && !er, nacc != a0)
  endtask
  initial begin
    {rst, sel, run, dis, promiscuous_mode, sam, fa, rclk, rdat, keep, low} = 21'h100000;
    repeat (3) @(negedge clk);
    {rst, run} = 2'h1;
    frame(1, 0, 0, 0, 8'h00, 4'h4, 1);
    frame(1, 0, 1, 0, 8'h00, 4'h4, 0);
    frame(1, 0, 0, 1, 8'h00, 4'h4, 0);
    frame(1, 0, 0, 0, 8'h00, 4'h1, 0);
    frame(1, 0, 0, 0, 8'h5A, 4'h4, 0);
    frame(1, 1, 0, 0, 8'h00, 4'h4, 1);
    frame(0, 0, 0, 0, 8'h00, 4'h4, 0);
    end_sim();
  end
endmodule
`default_nettype wire

// [eadp_sync.sv]
`default_nettype none
module eadp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } eadp_sync_t;
  eadp_sync_t st_reg, st_next;
  if (WIDTH < 1) begin : g_width_check
    $error("eadp_sync: WIDTH must be at least 1");
  end
  always_comb begin
    st_next = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign q = st_reg.s2;
endmodule
`default_nettype wire
